// ===== logic/camr_mask_regs.sv
// Acceptance mask register set of a receive filter, with its match result.
`timescale 1ns/1ps
`default_nettype none
module camr_mask_regs import camr_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic ext_format,
	input wire logic rx_valid,
	input wire logic [28:0] rx_id,
	input wire logic rx_rtr,
	input wire logic rx_ide,
	input wire logic [28:0] tag_id,
	input wire logic tag_rtr,
	input wire logic tag_ide,
	input wire logic tx_request,
	output logic [7:0] sfr_rdata,
	output logic rx_accept,
	output logic rx_reject,
	output logic tx_go,
	output logic [28:0] identifier_mask_bits,
	output logic remote_request_mask,
	output logic extension_flag_mask
);
	logic [7:0] mask_reg_first_q;
	logic [7:0] mask_reg_second_q;
	logic [7:0] mask_reg_third_q;
	logic [7:0] mask_reg_fourth_q;
	logic [7:0] sfr_rdata_q;
	logic rx_accept_q;
	logic rx_reject_q;
	logic tx_go_q;
	logic [28:0] id_mask_d;
	logic [28:0] id_mask_q;
	logic rtr_mask_q;
	logic ide_mask_q;
	logic [31:0] rx_vec;
	logic [31:0] tag_vec;
	logic [31:0] mask_vec;
	logic hit;

	// no reset
	// The mask bytes hold whatever software last wrote; reset leaves them alone on purpose.
	always_ff @(posedge clock) begin
		if (sfr_wr) begin
			unique case (sfr_addr)
				CAMR_ADDR_FIRST: mask_reg_first_q <= sfr_wdata;
				CAMR_ADDR_SECOND: mask_reg_second_q <= sfr_wdata;
				CAMR_ADDR_THIRD: mask_reg_third_q <= sfr_wdata;
				CAMR_ADDR_FOURTH: mask_reg_fourth_q <= sfr_wdata;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		id_mask_d = '0;
		if (ext_format) begin
			id_mask_d = {mask_reg_first_q, mask_reg_second_q, mask_reg_third_q,
				mask_reg_fourth_q[7:CAMR_ID_LOW_POS]};
		end else begin
			id_mask_d[CAMR_ID_STD_W-1:0] = {mask_reg_first_q,
				mask_reg_second_q[7:CAMR_STD_LOW_POS]};
		end
	end

	// Decoded masks are registered so the outputs come straight from flip-flops.
	always_ff @(posedge clock) begin
		id_mask_q <= id_mask_d;
		rtr_mask_q <= mask_reg_fourth_q[CAMR_RTR_POS];
		ide_mask_q <= mask_reg_fourth_q[CAMR_IDE_POS];
	end

	// reserved third
	// Reserved bytes read back as zero, one allowed value of an indeterminate read.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			unique case (sfr_addr)
				CAMR_ADDR_FIRST: sfr_rdata_q <= mask_reg_first_q;
				CAMR_ADDR_SECOND: sfr_rdata_q <= ext_format ? mask_reg_second_q
					: {mask_reg_second_q[7:CAMR_STD_LOW_POS], 5'b0_0000};
				CAMR_ADDR_THIRD: sfr_rdata_q <= ext_format ? mask_reg_third_q
					: CAMR_RSVD_READ;
				CAMR_ADDR_FOURTH: sfr_rdata_q <= ext_format
					? {mask_reg_fourth_q[7:CAMR_ID_LOW_POS],
						mask_reg_fourth_q[CAMR_RTR_POS], 1'b0,
						mask_reg_fourth_q[CAMR_IDE_POS]}
					: {5'b0_0000, mask_reg_fourth_q[CAMR_RTR_POS], 1'b0,
						mask_reg_fourth_q[CAMR_IDE_POS]};
				default: sfr_rdata_q <= CAMR_RSVD_READ;
			endcase
		end
	end

	assign rx_vec = {rx_id, rx_rtr, 1'b0, rx_ide};
	assign tag_vec = {tag_id, tag_rtr, 1'b0, tag_ide};
	assign mask_vec = {id_mask_q, rtr_mask_q, 1'b0, ide_mask_q};

	camr_compare #(
		.WIDTH(32)
	) u_compare (
		.rx_bits(rx_vec),
		.tag_bits(tag_vec),
		.mask_bits(mask_vec),
		.hit(hit)
	);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_accept_q <= 1'b0;
			rx_reject_q <= 1'b0;
		end else begin
			rx_accept_q <= rx_valid & hit;
			rx_reject_q <= rx_valid & ~hit;
		end
	end

	// transmit unaffected
	// Transmission request is registered and appears on tx_go one clock later; no mask bit enters this path.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_go_q <= 1'b0;
		end else begin
			tx_go_q <= tx_request;
		end
	end

	assign sfr_rdata = sfr_rdata_q;
	assign rx_accept = rx_accept_q;
	assign rx_reject = rx_reject_q;
	assign tx_go = tx_go_q;
	assign identifier_mask_bits = id_mask_q;
	assign remote_request_mask = rtr_mask_q;
	assign extension_flag_mask = ide_mask_q;

	accept_match_a: assert property (@(posedge clock) disable iff (!reset_n)
		rx_valid |=> rx_accept == ~|($past(mask_vec) & ($past(rx_vec) ^ $past(tag_vec))))
		else $error("accept does not follow masked compare");
	zero_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
		(rx_valid && mask_vec == 32'h0000_0000) |=> rx_accept)
		else $error("all-zero mask did not accept");
	compare_miss_a: assert property (@(posedge clock) disable iff (!reset_n)
		(rx_valid && (mask_vec & (rx_vec ^ tag_vec)) != 32'h0000_0000) |=> rx_reject)
		else $error("enabled mismatch was accepted");
	tx_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
		tx_request |=> tx_go)
		else $error("transmit request lost");
	ext_layout_a: assert property (@(posedge clock) disable iff (!reset_n)
		(ext_format && $stable(ext_format)) |=> identifier_mask_bits[28:21]
			== $past(mask_reg_first_q))
		else $error("extended high byte misplaced");
	std_layout_a: assert property (@(posedge clock) disable iff (!reset_n)
		!ext_format |=> identifier_mask_bits[28:11] == 18'h0_0000)
		else $error("standard mask has upper bits");
	rsvd_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sfr_rd && !ext_format && sfr_addr == CAMR_ADDR_THIRD) |=> sfr_rdata == 8'h00)
		else $error("reserved byte read nonzero");
	// Bus steps used by the layout and readback checks below.
	// Mask bytes are unknown until written, so checks start from a write, not from reset.
	sequence s_wr_first;
		sfr_wr && sfr_addr == CAMR_ADDR_FIRST;
	endsequence : s_wr_first
	sequence s_rd_first_gap;
		!sfr_wr ##1 (sfr_rd && !sfr_wr && sfr_addr == CAMR_ADDR_FIRST);
	endsequence : s_rd_first_gap
	sequence s_wr_fourth;
		sfr_wr && sfr_addr == CAMR_ADDR_FOURTH;
	endsequence : s_wr_fourth
	sequence s_wr_first_std;
		(sfr_wr && sfr_addr == CAMR_ADDR_FIRST && !ext_format) ##1 !ext_format;
	endsequence : s_wr_first_std
	sequence s_wr_second_std;
		(sfr_wr && sfr_addr == CAMR_ADDR_SECOND && !ext_format) ##1 !ext_format;
	endsequence : s_wr_second_std
	sequence s_wr_second_ext;
		(sfr_wr && sfr_addr == CAMR_ADDR_SECOND && ext_format) ##1 ext_format;
	endsequence : s_wr_second_ext
	sequence s_wr_third_ext;
		(sfr_wr && sfr_addr == CAMR_ADDR_THIRD && ext_format) ##1 ext_format;
	endsequence : s_wr_third_ext
	sequence s_wr_fourth_ext;
		(sfr_wr && sfr_addr == CAMR_ADDR_FOURTH && ext_format) ##1 ext_format;
	endsequence : s_wr_fourth_ext

	rtr_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_fourth |=> ##1 remote_request_mask == $past(sfr_wdata[CAMR_RTR_POS], 2))
		else $error("remote mask not from bit 2");
	ide_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_fourth |=> ##1 extension_flag_mask == $past(sfr_wdata[CAMR_IDE_POS], 2))
		else $error("extension mask not from bit 0");
	wr_rd_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_first ##1 s_rd_first_gap |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("first mask readback wrong");
	ext_second_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_second_ext |=> identifier_mask_bits[20:13] == $past(sfr_wdata, 2))
		else $error("extended second byte misplaced");
	ext_third_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_third_ext |=> identifier_mask_bits[12:5] == $past(sfr_wdata, 2))
		else $error("extended third byte misplaced");
	ext_low_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_fourth_ext |=> identifier_mask_bits[4:0]
			== $past(sfr_wdata[7:CAMR_ID_LOW_POS], 2))
		else $error("extended low bits misplaced");
	std_high_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_first_std |=> identifier_mask_bits[10:3] == $past(sfr_wdata, 2))
		else $error("standard high bits misplaced");
	std_low_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_wr_second_std |=> identifier_mask_bits[2:0]
			== $past(sfr_wdata[7:CAMR_STD_LOW_POS], 2))
		else $error("standard low bits misplaced");
	std_second_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sfr_rd && !ext_format && sfr_addr == CAMR_ADDR_SECOND) |=> sfr_rdata[4:0] == 5'h00)
		else $error("standard second byte low bits nonzero");
	std_fourth_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sfr_rd && !ext_format && sfr_addr == CAMR_ADDR_FOURTH) |=> sfr_rdata[7:3] == 5'h00)
		else $error("standard fourth byte high bits nonzero");
	rsvd_bit_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sfr_rd && sfr_addr == CAMR_ADDR_FOURTH) |=> !sfr_rdata[CAMR_RB1_POS])
		else $error("reserved fourth bit read nonzero");
	other_addr_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sfr_rd && (sfr_addr < CAMR_ADDR_FIRST || sfr_addr > CAMR_ADDR_FOURTH))
			|=> sfr_rdata == CAMR_RSVD_READ)
		else $error("foreign address read nonzero");
	rdata_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	one_verdict_a: assert property (@(posedge clock) disable iff (!reset_n)
		!(rx_accept && rx_reject))
		else $error("frame both accepted and rejected");
	idle_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
		!rx_valid |=> !rx_accept && !rx_reject)
		else $error("verdict without a received frame");
	tx_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		!tx_request |=> !tx_go)
		else $error("transmit started without request");
endmodule : camr_mask_regs
`default_nettype wire

// ===== logic/camr_pkg.sv
// Package with addresses, field positions and widths of the acceptance mask registers.
package camr_pkg;
	localparam logic [7:0] CAMR_ADDR_FIRST = 8'hC4;
	localparam logic [7:0] CAMR_ADDR_SECOND = 8'hC5;
	localparam logic [7:0] CAMR_ADDR_THIRD = 8'hC6;
	localparam logic [7:0] CAMR_ADDR_FOURTH = 8'hC7;
	localparam int CAMR_ID_EXT_W = 29;
	localparam int CAMR_ID_STD_W = 11;
	localparam int CAMR_RTR_POS = 2;
	localparam int CAMR_RB1_POS = 1;
	localparam int CAMR_IDE_POS = 0;
	localparam int CAMR_ID_LOW_POS = 3;
	localparam int CAMR_STD_LOW_POS = 5;
	localparam int CAMR_REG_NUM = 4;
	localparam logic [7:0] CAMR_RSVD_READ = 8'h00;
endpackage : camr_pkg

// ===== logic/camr_compare.sv
// Masked comparison of one received field against its stored tag.
`timescale 1ns/1ps
`default_nettype none
module camr_compare import camr_pkg::*; #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] rx_bits,
	input wire logic [WIDTH-1:0] tag_bits,
	input wire logic [WIDTH-1:0] mask_bits,
	output logic hit
);
	logic [WIDTH-1:0] miss;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign miss[i] = mask_bits[i] & (rx_bits[i] ^ tag_bits[i]);
		end
	endgenerate
	assign hit = ~|miss;
endmodule : camr_compare
`default_nettype wire

// ===== test/tb_camr_mask_regs.sv
// Random and corner-case bench for the acceptance mask registers.
`timescale 1ns/1ps
`default_nettype none
module tb_camr_mask_regs import camr_pkg::*;;
	logic clock = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, ext_format = 0, rx_valid = 0;
	logic rx_rtr = 0, rx_ide = 0, tag_rtr = 0, tag_ide = 0, tx_request = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic [28:0] rx_id = 29'h0000_0000, tag_id = 29'h0000_0000;
	wire logic [7:0] sfr_rdata;
	wire logic [28:0] idm;
	wire logic rx_accept, rx_reject, tx_go, rtm, efm;
	int n_mismatch = 0, n_checks = 0, seed = 32'h05e4;
	logic [7:0] m [4];
	camr_mask_regs i_dut (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .ext_format(ext_format),
		.rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide), .tag_id(tag_id),
		.tag_rtr(tag_rtr), .tag_ide(tag_ide), .tx_request(tx_request), .sfr_rdata(sfr_rdata),
		.rx_accept(rx_accept), .rx_reject(rx_reject), .tx_go(tx_go),
		.identifier_mask_bits(idm), .remote_request_mask(rtm), .extension_flag_mask(efm));
	initial begin
		forever #2 clock = ~clock;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask : wr
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		sfr_rd <= 1'b1; sfr_addr <= a;
		@(posedge clock);
		sfr_rd <= 1'b0;
		#1 check(32'(sfr_rdata), 32'(exp));
	endtask : rd_chk
	function automatic logic [28:0] exp_id(input logic ext);
		return ext ? {m[0], m[1], m[2], m[3][7:3]} : {18'h0_0000, m[0], m[1][7:5]};
	endfunction : exp_id
	// Readable bits per layout; reserved places read as zero.
	function automatic logic [7:0] rd_mask(input int i, input logic ext);
		logic [31:0] k;
		k = ext ? 32'hFFFF_FFFD : 32'hFFE0_0005;
		return k[31-8*i -: 8];
	endfunction : rd_mask
	task frame();
		int r;
		logic [28:0] f, t;
		logic [1:0] g;
		logic e;
		r = $random(seed);
		t = 29'($random(seed));
		f = (r[1:0] == 2'h0) ? 29'h0000_0000 : (29'h0000_0001 << (r[9:2] % 29));
		g = r[13] ? r[15:14] : 2'h0;
		e = ((exp_id(ext_format) & f) == 0) && !(g[1] & m[3][2]) && !(g[0] & m[3][0]);
		@(posedge clock);
		rx_valid <= 1'b1; tag_id <= t; rx_id <= t ^ f; tx_request <= r[17];
		tag_rtr <= r[18]; rx_rtr <= r[18] ^ g[1]; tag_ide <= r[19]; rx_ide <= r[19] ^ g[0];
		@(posedge clock);
		rx_valid <= 1'b0; tx_request <= 1'b0;
		#1 check(32'({rx_accept, rx_reject, tx_go}), 32'({e, !e, r[17]}));
	endtask : frame
	initial begin
		#20000 n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		// Modes: all compare, all forced, then random masks, in each layout.
		for (int p = 0; p < 6; p++) begin
			ext_format <= p[0];
			for (int i = 0; i < 4; i++) begin
				m[i] = (p < 2) ? 8'hFF : (p < 4) ? 8'h00 : 8'($random(seed));
			end
			m[3][1] = 1'b0;
			for (int i = 0; i < 4; i++) wr(CAMR_ADDR_FIRST + 8'(i), m[i]);
			repeat (2) @(posedge clock);
			#1 check(32'(idm), 32'(exp_id(p[0])));
			check(32'({rtm, efm}), 32'({m[3][2], m[3][0]}));
			for (int i = 0; i < 4; i++) rd_chk(CAMR_ADDR_FIRST + 8'(i), m[i] & rd_mask(i, p[0]));
			rd_chk(8'hC8, 8'h00);
			wr(CAMR_ADDR_FIRST, m[0]);
			rd_chk(CAMR_ADDR_FIRST, m[0]);
			repeat (40) frame();
			$display("test layout %0d masks %0d done", p[0], p / 2);
		end
		// A second reset must leave the stored masks alone.
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(CAMR_ADDR_FIRST, m[0]);
		print_verdict();
	end
endmodule : tb_camr_mask_regs
`default_nettype wire
